// [verilog/dttd_pkg.sv]
// Purpose: shared constants and carriers for the dual timer block
// Assumes: 32-bit AXI4-Lite, byte address is four times register index
// Notes: register index constants keep the printed offsets
package dttd_pkg;
    localparam int AXI_AW = 8;
    localparam logic [5:0] IDX_COMMON        = 6'h01;
    localparam logic [5:0] IDX_WIDE_CTL      = 6'h02;
    localparam logic [5:0] IDX_NARROW_CTL    = 6'h03;
    localparam logic [5:0] IDX_NARROW_RELOAD = 6'h04;
    localparam logic [5:0] IDX_WIDE_RELOAD   = 6'h05;
    localparam logic [5:0] IDX_CAPTURE       = 6'h06;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Common control fields
    localparam int COM_MODE  = 7;
    localparam int COM_SEL   = 6;
    localparam int COM_LOGIC = 4;
    localparam int COM_SUB   = 2;
    localparam int COM_INIT8 = 1;
    localparam int COM_INIT16 = 0;
    // Wide timer control fields
    localparam int WC_EN     = 7;
    localparam int WC_SINGLE = 6;
    localparam int WC_TOUT   = 5;
    localparam int WC_PRE    = 3;
    localparam int WC_CAPMSK = 2;
    localparam int WC_TOMSK  = 1;
    localparam int WC_PINOUT = 0;
    localparam int CAP_FLAG  = 16;
    localparam logic [7:0] COMMON_RST = 8'h00;
    localparam logic [7:0] WCTL_RST   = 8'h00;
    localparam logic [7:0] NCTL_RST   = 8'h00;
    localparam logic [7:0] WCTL_KEEP  = 8'h1C;
    localparam logic [1:0] SUB_NORMAL   = 2'h0;
    localparam logic [1:0] SUB_PINGPONG = 2'h1;
    localparam logic [1:0] SUB_FORCE_LO = 2'h2;
    localparam logic [1:0] SUB_FORCE_HI = 2'h3;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] LOGIC_AND = 2'h0;
    localparam logic [1:0] LOGIC_OR  = 2'h1;
    localparam logic [1:0] LOGIC_NOR = 2'h2;
    localparam logic [1:0] FILT_4 = 2'h1;
    localparam logic [1:0] FILT_8 = 2'h2;
    localparam logic [3:0] FILT_4_LEN = 4'h4;
    localparam logic [3:0] FILT_8_LEN = 4'h8;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } dttd_axil_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dttd_axil_rsp_type;

    typedef struct packed {
        logic [7:0]        common;
        logic [7:0]        wctl;
        logic [7:0]        nctl;
        logic [7:0]        nreload;
        logic [15:0]       wreload;
        logic [15:0]       capture;
        logic              capflag;
        logic [7:0]        ncount;
        logic [15:0]       wcount;
        logic              nout;
        logic              wout;
        logic              n_armed;
        logic              w_armed;
        logic              seen;
        logic              aw_have;
        logic [AXI_AW-1:0] awaddr;
        logic              w_have;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } dttd_core_type;

    typedef struct packed {
        logic       stable;
        logic [3:0] cnt;
        logic       rise;
        logic       fall;
    } dttd_filt_type;
endpackage

// [verilog/dttd_prescale.sv]
// Purpose: count clock enable for the wide timer
// Assumes: sel 0..3 gives divide by 1, 2, 4, 8
// Notes: divider restarts while the timer is stopped
`timescale 1ns/10ps
module dttd_prescale
    import dttd_pkg::*;
#(
    parameter int DIV_BITS = 3
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       run,
    input  wire logic [1:0] sel,
    output logic            tick
);
    if (DIV_BITS < 3) begin : g_chk
        $error("dttd_prescale: DIV_BITS below 3");
    end
    logic [DIV_BITS-1:0] cnt_q;
    logic [DIV_BITS-1:0] cnt_d;
    logic [DIV_BITS-1:0] mask;

    always_comb begin
        mask = DIV_BITS'((1 << sel) - 1);
        tick = run && ((cnt_q & mask) == mask);
        cnt_d = run ? DIV_BITS'(cnt_q + 1'b1) : '0;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    a_div8_spacing: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && sel == 2'h3) |=> (!tick || sel != 2'h3) [*7])
        else $error("divide by 8 tick too early");
endmodule // dttd_prescale

// [verilog/dttd_filter.sv]
// Purpose: glitch filter and edge pulses for the demodulator input
// Assumes: input already synchronous to clk
// Notes: reserved length code behaves as no filter
`timescale 1ns/10ps
module dttd_filter
    import dttd_pkg::*;
#(
    parameter int MAX_LEN = 8
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       raw,
    input  wire logic [1:0] len_sel,
    output logic            rise,
    output logic            fall
);
    if (MAX_LEN < 8 || MAX_LEN > 15) begin : g_chk
        $error("dttd_filter: MAX_LEN out of range");
    end
    dttd_filt_type s_q;
    dttd_filt_type s_d;
    logic [3:0]    need;

    always_comb begin
        s_d = s_q;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        unique case (len_sel)
            FILT_4:  need = FILT_4_LEN;
            FILT_8:  need = FILT_8_LEN;
            default: need = 4'h1;
        endcase
        if (raw == s_q.stable) begin
            s_d.cnt = 4'h0;
        end else if (s_q.cnt == 4'(need - 4'h1)) begin
            s_d.stable = raw;
            s_d.cnt = 4'h0;
            s_d.rise = raw;
            s_d.fall = !raw;
        end else begin
            s_d.cnt = 4'(s_q.cnt + 4'h1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign rise = s_q.rise;
    assign fall = s_q.fall;

    a_filter_four: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.rise && len_sel == FILT_4) |-> ($past(raw, 1) &&
        $past(raw, 2) && $past(raw, 3) && $past(raw, 4)))
        else $error("rise passed filter too soon");
endmodule // dttd_filter

// [verilog/dttd_top.sv]
// Purpose: control of a narrow and a wide timer, transmit and demodulation
// Assumes: AXI4-Lite slave, 32-bit data, pins synchronous to clk
// Notes: one write and one read in flight; unmapped address gives SLVERR
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
module dttd_top
    import dttd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire dttd_axil_req_type axil_req,
    output dttd_axil_rsp_type      axil_rsp,
    input  wire logic              stop_recover,
    input  wire logic              demod_input_pin_a,
    input  wire logic              demod_input_pin_b,
    input  wire logic              port_wide_data,
    input  wire logic              port_combined_data,
    output logic                   narrow_timer_output,
    output logic                   wide_timer_output,
    output logic                   wide_timer_pin,
    output logic                   combined_output_pin,
    output logic                   wide_timeout_irq,
    output logic                   capture_irq
);
    dttd_core_type s_q;
    dttd_core_type s_d;
    logic          tick;
    logic          rise_ev;
    logic          fall_ev;
    logic          demod;
    logic          sel_edge;
    logic [1:0]    sub;
    logic          n_term;
    logic          w_term;
    logic          nto_ev;
    logic          wto_ev;
    logic          cap_ev;
    logic          do_wr;
    logic [5:0]    wr_idx;
    logic          wr_ok;
    logic [31:0]   rd_data;
    logic          rd_ok;
    logic          combo;

    function automatic logic reg_known(input logic [AXI_AW-1:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        reg_known = (addr[1:0] == 2'h0) &&
                    (idx >= IDX_COMMON) && (idx <= IDX_CAPTURE);
    endfunction

    dttd_prescale #(
        .DIV_BITS (3)
    ) u_prescale (
        .clk   (clk),
        .rst_b (rst_b),
        .run   (s_q.wctl[WC_EN]),
        .sel   (s_q.wctl[WC_PRE +: 2]),
        .tick  (tick)
    );

    dttd_filter #(
        .MAX_LEN (8)
    ) u_filter (
        .clk     (clk),
        .rst_b   (rst_b),
        .raw     (s_q.common[COM_SEL] ? demod_input_pin_b
                                      : demod_input_pin_a),
        .len_sel (s_q.common[COM_SUB +: 2]),
        .rise    (rise_ev),
        .fall    (fall_ev)
    );

    // Read mux
    always_comb begin
        rd_ok = reg_known(axil_req.araddr);
        rd_data = 32'h0000_0000;
        unique case (axil_req.araddr[7:2])
            IDX_COMMON:        rd_data[7:0] = s_q.common;
            IDX_WIDE_CTL:      rd_data[7:0] = s_q.wctl;
            IDX_NARROW_CTL:    rd_data[7:0] = s_q.nctl;
            IDX_NARROW_RELOAD: rd_data[7:0] = s_q.nreload;
            IDX_WIDE_RELOAD:   rd_data[15:0] = s_q.wreload;
            IDX_CAPTURE:       rd_data[16:0] = {s_q.capflag, s_q.capture};
            default:           rd_data = 32'h0000_0000;
        endcase
    end

    always_comb begin
        demod = s_q.common[COM_MODE];
        sub = s_q.common[COM_SUB +: 2];
        unique case (s_q.common[COM_LOGIC +: 2])
            EDGE_FALL: sel_edge = fall_ev;
            EDGE_RISE: sel_edge = rise_ev;
            EDGE_BOTH: sel_edge = rise_ev || fall_ev;
            default:   sel_edge = 1'b0;
        endcase
        wr_idx = s_q.awaddr[7:2];
        wr_ok = reg_known(s_q.awaddr);
        do_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    end

    always_comb begin
        s_d = s_q;
        n_term = 1'b0;
        w_term = 1'b0;
        nto_ev = 1'b0;
        wto_ev = 1'b0;
        cap_ev = 1'b0;
        // Bus channels
        if (!s_q.aw_have && axil_req.awvalid) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = axil_req.awaddr;
        end
        if (!s_q.w_have && axil_req.wvalid) begin
            s_d.w_have = 1'b1;
            s_d.wdata = axil_req.wdata;
            s_d.wstrb = axil_req.wstrb;
        end
        if (s_q.bvalid && axil_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && axil_req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (axil_req.arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_data;
            s_d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        // Narrow timer, system clock rate
        if (!s_q.nctl[WC_EN]) begin
            s_d.nout = !s_q.common[COM_INIT8];
            s_d.n_armed = 1'b0;
        end else if (!s_q.n_armed) begin
            s_d.nout = s_q.common[COM_INIT8];
            s_d.ncount = s_q.nreload;
            s_d.n_armed = 1'b1;
        end else if (s_q.ncount <= 8'h01) begin
            n_term = 1'b1;
            nto_ev = 1'b1;
            s_d.nout = !s_q.nout;
            s_d.ncount = s_q.nreload;
            if (s_q.nctl[WC_SINGLE]) begin
                s_d.nctl[WC_EN] = 1'b0;
            end
        end else begin
            s_d.ncount = 8'(s_q.ncount - 8'h01);
        end
        // Wide timer, prescaled rate
        if (!s_q.wctl[WC_EN]) begin
            s_d.wout = !s_q.common[COM_INIT16];
            s_d.w_armed = 1'b0;
        end else if (!s_q.w_armed) begin
            s_d.wout = s_q.common[COM_INIT16];
            s_d.wcount = s_q.wreload;
            s_d.w_armed = 1'b1;
            s_d.seen = 1'b0;
        end else begin
            if (tick) begin
                if (s_q.wcount <= 16'h0001) begin
                    w_term = 1'b1;
                    wto_ev = 1'b1;
                    s_d.wcount = s_q.wreload;
                    if (!demod) begin
                        s_d.wout = !s_q.wout;
                        if (s_q.wctl[WC_SINGLE]) begin
                            s_d.wctl[WC_EN] = 1'b0;
                        end
                    end
                end else begin
                    s_d.wcount = 16'(s_q.wcount - 16'h0001);
                end
            end
            if (demod && sel_edge && !(s_q.wctl[WC_SINGLE] && s_q.seen)) begin
                s_d.capture = 16'(s_q.wreload - s_q.wcount);
                s_d.wcount = s_q.wreload;
                s_d.seen = 1'b1;
                cap_ev = 1'b1;
            end
        end
        // Alternate the two timers, then apply forced wide levels
        if (!demod && sub == SUB_PINGPONG) begin
            if (n_term) begin
                s_d.nctl[WC_EN] = 1'b0;
                s_d.wctl[WC_EN] = 1'b1;
            end
            if (w_term) begin
                s_d.wctl[WC_EN] = 1'b0;
                s_d.nctl[WC_EN] = 1'b1;
            end
        end
        if (!demod && sub == SUB_FORCE_LO) begin
            s_d.wout = 1'b0;
        end else if (!demod && sub == SUB_FORCE_HI) begin
            s_d.wout = 1'b1;
        end
        // Register writes
        if (do_wr) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (do_wr && wr_ok && s_q.wstrb[0]) begin
            unique case (wr_idx)
                IDX_COMMON: begin
                    s_d.common = s_q.wdata[7:0];
                    if (demod) begin
                        s_d.common[1:0] = s_q.common[1:0] &
                                          ~s_q.wdata[1:0];
                    end
                end
                IDX_WIDE_CTL: begin
                    s_d.wctl = s_q.wdata[7:0];
                    s_d.wctl[WC_TOUT] = s_q.wctl[WC_TOUT] &&
                                        !s_q.wdata[WC_TOUT];
                end
                IDX_NARROW_CTL: begin
                    s_d.nctl = {s_q.wdata[7:6],
                                s_q.nctl[WC_TOUT] && !s_q.wdata[WC_TOUT],
                                5'h00};
                end
                IDX_NARROW_RELOAD: s_d.nreload = s_q.wdata[7:0];
                IDX_WIDE_RELOAD: s_d.wreload[7:0] = s_q.wdata[7:0];
                default: ;
            endcase
        end
        if (do_wr && wr_ok && wr_idx == IDX_WIDE_RELOAD && s_q.wstrb[1]) begin
            s_d.wreload[15:8] = s_q.wdata[15:8];
        end
        if (do_wr && wr_ok && wr_idx == IDX_CAPTURE && s_q.wstrb[2] &&
            s_q.wdata[CAP_FLAG]) begin
            s_d.capflag = 1'b0;
        end
        if (stop_recover) begin
            s_d.common = COMMON_RST;
            s_d.nctl = NCTL_RST;
            s_d.wctl = (s_q.wctl & WCTL_KEEP) |
                       (WCTL_RST & ~WCTL_KEEP);
        end
        // Hardware sets win over clears
        if (demod) begin
            s_d.common[COM_INIT8] = s_d.common[COM_INIT8] ||
                                    rise_ev;
            s_d.common[COM_INIT16] = s_d.common[COM_INIT16] ||
                                     fall_ev;
        end
        s_d.wctl[WC_TOUT] = s_d.wctl[WC_TOUT] || wto_ev;
        s_d.nctl[WC_TOUT] = s_d.nctl[WC_TOUT] || nto_ev;
        s_d.capflag = s_d.capflag || cap_ev;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Pin and response outputs
    always_comb begin
        unique case (s_q.common[COM_LOGIC +: 2])
            LOGIC_AND: combo = s_q.nout && s_q.wout;
            LOGIC_OR:  combo = s_q.nout || s_q.wout;
            LOGIC_NOR: combo = !(s_q.nout || s_q.wout);
            default:   combo = !(s_q.nout && s_q.wout);
        endcase
        combined_output_pin = (!demod && s_q.common[COM_SEL]) ?
                              combo : port_combined_data;
        wide_timer_pin = s_q.wctl[WC_PINOUT] ?
                         s_q.wout : port_wide_data;
        narrow_timer_output = s_q.nout;
        wide_timer_output = s_q.wout;
        wide_timeout_irq = s_q.wctl[WC_TOUT] && s_q.wctl[WC_TOMSK];
        capture_irq = s_q.capflag && s_q.wctl[WC_CAPMSK];
        axil_rsp.awready = !s_q.aw_have;
        axil_rsp.wready = !s_q.w_have;
        axil_rsp.bvalid = s_q.bvalid;
        axil_rsp.bresp = s_q.bresp;
        axil_rsp.arready = !s_q.rvalid;
        axil_rsp.rvalid = s_q.rvalid;
        axil_rsp.rdata = s_q.rdata;
        axil_rsp.rresp = s_q.rresp;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_narrow_start_level: assert property (
        (s_q.nctl[WC_EN] && !s_q.n_armed) |=>
        (s_q.nout == $past(s_q.common[COM_INIT8])))
        else $error("narrow output not at initial level");
    a_narrow_idle_level: assert property (
        (rst_b && !s_q.nctl[WC_EN]) |=>
        (s_q.nout == !$past(s_q.common[COM_INIT8])))
        else $error("idle narrow output not inverted");
    a_rise_flag_set: assert property (
        (demod && rise_ev) |=> s_q.common[COM_INIT8])
        else $error("rising edge flag missed");
    a_wide_start_level: assert property (
        (!demod && !sub[1] && s_q.wctl[WC_EN] && !s_q.w_armed) |=>
        (s_q.wout == $past(s_q.common[COM_INIT16])))
        else $error("wide output not at initial level");
    a_wide_idle_level: assert property (
        (rst_b && !demod && !sub[1] && !s_q.wctl[WC_EN]) |=>
        (s_q.wout == !$past(s_q.common[COM_INIT16])))
        else $error("idle wide output not inverted");
    a_fall_flag_set: assert property (
        (demod && fall_ev) |=> s_q.common[COM_INIT16])
        else $error("falling edge flag missed");
    a_single_pass_stop: assert property (
        (!demod && sub == SUB_NORMAL && s_q.wctl[WC_SINGLE] && w_term &&
         !do_wr) |=> !s_q.wctl[WC_EN])
        else $error("single pass did not stop");
    a_capture_first_only: assert property (
        (demod && s_q.wctl[WC_SINGLE] && s_q.seen && s_q.w_armed) |-> !cap_ev)
        else $error("capture after first edge");
    a_timeout_sticky: assert property (
        (s_q.wctl[WC_TOUT] && !stop_recover &&
         !(do_wr && wr_idx == IDX_WIDE_CTL)) |=> s_q.wctl[WC_TOUT])
        else $error("timeout flag lost");

    c_alternating_submode_swap: cover property (
        (!demod && sub == SUB_PINGPONG && n_term) ##[1:40] w_term);
    c_capture: cover property (demod && cap_ev);
    c_wide_timeout: cover property (wto_ev ##1 wide_timeout_irq);
endmodule // dttd_top

// [testbench/dttd_pin_model.sv]
// Purpose: port pin model feeding the demodulator inputs
// Assumes: levels change just after a clock edge
// Notes: pins read low while reset is held
`timescale 1ns/10ps
module dttd_pin_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic want_a,
    input  wire logic want_b,
    output logic      pin_a = 1'h0,
    output logic      pin_b = 1'h0
);
    always @(posedge clk) begin
        pin_a <= rst_b & want_a;
        pin_b <= rst_b & want_b;
    end
endmodule // dttd_pin_model

// [testbench/tb_dual_timer_transmit_demod_control.sv]
// Purpose: self-checking bench for the dual timer control block
// Assumes: byte address is four times the register index
// Notes: random init bits and port data, seed fixed
`timescale 1ns/10ps
module tb_dual_timer_transmit_demod_control
    import dttd_pkg::*;
;
    logic              clk = 1'h0;
    logic              rst_b = 1'h0;
    dttd_axil_req_type req = '0;
    dttd_axil_rsp_type rsp;
    logic              stop_recover = 1'h0;
    logic              pwd = 1'h0;
    logic              pcd = 1'h0;
    logic              want_a = 1'h0;
    logic              want_b = 1'h0;
    logic [31:0]       cap = 32'h0;
    logic              pin_a, pin_b, nout, wout, wpin, cpin, tirq, cirq;
    logic [31:0]       rd = 32'h0;
    logic [1:0]        rr, ib;
    int                miscompares = 0, n_checks = 0, seed = 24, i;

    always #20 clk = ~clk;

    dttd_pin_model pin_u (.clk(clk), .rst_b(rst_b), .want_a(want_a),
        .want_b(want_b), .pin_a(pin_a), .pin_b(pin_b));
    dttd_top dut_u (.clk(clk), .rst_b(rst_b), .axil_req(req), .axil_rsp(rsp),
        .stop_recover(stop_recover), .demod_input_pin_a(pin_a),
        .demod_input_pin_b(pin_b), .port_wide_data(pwd),
        .port_combined_data(pcd), .narrow_timer_output(nout),
        .wide_timer_output(wout), .wide_timer_pin(wpin),
        .combined_output_pin(cpin), .wide_timeout_irq(tirq),
        .capture_irq(cirq));

    task summarize;
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    function logic comb(input logic [1:0] c, input logic a, input logic b);
        case (c)
            2'h0: comb = a & b;
            2'h1: comb = a | b;
            2'h2: comb = !(a | b);
            default: comb = !(a & b);
        endcase
    endfunction

    task axw(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hF;
        req.awvalid <= 1'h1;
        req.wvalid <= 1'h1;
        req.bready <= 1'h1;
        for (int k = 0; k < 50; k++) begin
            @(negedge clk);
            ta = req.awvalid & rsp.awready;
            tw = req.wvalid & rsp.wready;
            tb = rsp.bvalid;
            @(posedge clk);
            if (ta) req.awvalid <= 1'h0;
            if (tw) req.wvalid <= 1'h0;
            if (tb) begin
                req.bready <= 1'h0;
                return;
            end
        end
        miscompares++;
        summarize;
    endtask

    task axr(input logic [7:0] a);
        logic ta, tr;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'h1;
        req.rready <= 1'h1;
        for (int k = 0; k < 50; k++) begin
            @(negedge clk);
            ta = req.arvalid & rsp.arready;
            tr = rsp.rvalid;
            rd = rsp.rdata;
            rr = rsp.rresp;
            @(posedge clk);
            if (ta) req.arvalid <= 1'h0;
            if (tr) begin
                req.rready <= 1'h0;
                return;
            end
        end
        miscompares++;
        summarize;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        axr(8'h04);
        chk(rd, 32'h0);
        axr(8'h08);
        chk(rd, 32'h0);
        axr(8'h40);
        chk(rr, RESP_SLVERR);
        // Timers idle: outputs are complements, pin combines them
        for (i = 0; i < 8; i++) begin
            ib = 2'($random(seed));
            axw(8'h04, {2'h1, i[1:0], 2'h0, ib});
            pcd <= 1'($random(seed));
            @(negedge clk);
            chk(nout, !ib[1]);
            chk(wout, !ib[0]);
            chk(cpin, comb(i[1:0], !ib[1], !ib[0]));
        end
        // Single pass wide timer: timeout flag, write-one clear, stop recovery
        axw(8'h04, 8'h01);
        @(negedge clk);
        chk(cpin, pcd);
        axw(8'h14, 8'h05);
        pwd <= 1'($random(seed));
        axw(8'h08, 8'hC3);
        @(negedge clk);
        chk(wout, 1'h1);
        chk(wpin, 1'h1);
        rd = 32'h0;
        for (i = 0; i < 40 && !rd[5]; i++) axr(8'h08);
        chk(rd, 32'h63);
        chk(tirq, 1'h1);
        chk(wpin, 1'h0);
        axw(8'h08, 8'h43);
        axr(8'h08);
        chk(rd, 32'h63);
        axw(8'h08, 8'h63);
        axr(8'h08);
        chk(rd, 32'h43);
        axw(8'h08, 8'h1C);
        stop_recover <= 1'h1;
        @(posedge clk);
        stop_recover <= 1'h0;
        axr(8'h08);
        chk(rd, 32'h1C);
        @(negedge clk);
        chk(wpin, pwd);
        // Demod on pin a: one rise and one fall
        axw(8'h04, 8'h80);
        want_a <= 1'h1;
        repeat (4) @(posedge clk);
        want_a <= 1'h0;
        repeat (4) @(posedge clk);
        axr(8'h04);
        chk(rd, 32'h83);
        axw(8'h04, 8'h83);
        axr(8'h04);
        chk(rd, 32'h80);
        // Pin b selected: pin a ignored, edge on b flagged
        axw(8'h04, 8'hC0);
        want_a <= 1'h1;
        repeat (4) @(posedge clk);
        want_a <= 1'h0;
        repeat (4) @(posedge clk);
        axr(8'h04);
        chk(rd, 32'hC0);
        want_b <= 1'h1;
        repeat (4) @(posedge clk);
        axr(8'h04);
        chk(rd, 32'hC2);
        want_b <= 1'h0;
        // Single capture: second falling edge ignored
        axw(8'h04, 8'h80);
        axw(8'h14, 8'hFF);
        axw(8'h08, 8'hC4);
        for (i = 0; i < 2; i++) begin
            want_a <= 1'h1;
            repeat (4) @(posedge clk);
            want_a <= 1'h0;
            repeat (4) @(posedge clk);
            axr(8'h18);
            if (i == 0) cap = rd;
            chk(rd[16], 1'h1);
            chk(cirq, 1'h1);
            chk(rd, cap);
        end
        // Divide by 8: still counting after 12 clocks, done by 23
        axw(8'h08, 8'h00);
        axw(8'h04, 8'h00);
        axw(8'h14, 8'h02);
        axw(8'h08, 8'hD8);
        repeat (8) @(posedge clk);
        axr(8'h08);
        chk(rd, 32'hD8);
        repeat (8) @(posedge clk);
        axr(8'h08);
        chk(rd, 32'h78);
        // Forced wide levels override the idle level
        axw(8'h04, 8'h08);
        @(negedge clk);
        chk(wout, 1'h0);
        axw(8'h04, 8'h0D);
        @(negedge clk);
        chk(wout, 1'h1);
        // Alternation: narrow runs first, then hands over
        axw(8'h08, 8'h60);
        axw(8'h04, 8'h04);
        axw(8'h10, 8'h03);
        axw(8'h14, 8'h03);
        axw(8'h0C, 8'hC0);
        @(negedge clk);
        chk(nout, 1'h0);
        repeat (8) @(posedge clk);
        axr(8'h08);
        chk(rd[5], 1'h1);
        axr(8'h0C);
        chk(rd[5], 1'h1);
        summarize;
    end
endmodule // tb_dual_timer_transmit_demod_control
